// ### fod_pkg.sv
package fod_pkg;

  // serial frame layout: write flag, address, data, most significant bit first
  localparam int FRAME_BITS = 16;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 8;
  localparam logic [4:0] FRAME_BITS_M1 = 5'h0F;

  // register addresses on the serial link
  localparam logic [ADDR_W-1:0] ADDR_SETUP = 7'h01;
  localparam logic [ADDR_W-1:0] ADDR_PREP = 7'h02;
  localparam logic [ADDR_W-1:0] ADDR_ADIM = 7'h03;

  // discharge_setup_reg field positions
  localparam int CHAIN_W = 4;
  localparam int START_POS = 4;
  localparam int HALVE_POS = 5;
  localparam int SOFTEN_POS = 6;
  localparam int DONE_POS = 7;

  // values after reset
  localparam logic [DATA_W-1:0] SETUP_RST = 8'h00;
  localparam logic [DATA_W-1:0] PREP_RST = 8'h00;
  localparam logic [DATA_W-1:0] ADIM_RST = 8'hFF;

  // timing: switching period derived from the core clock
  localparam int CLK_FREQ_KHZ = 20000;
  localparam int SW_FREQ_KHZ = 400;
  localparam int SW_DIV = CLK_FREQ_KHZ / SW_FREQ_KHZ;
  localparam logic [7:0] SW_DIV_M1 = 8'(SW_DIV - 1);
  localparam logic [8:0] PREP_BASE_PERIODS = 9'h002;

  // converter output sense width
  localparam int VOUT_W = 10;

  typedef enum logic [1:0] {
    FOD_IDLE = 2'b00,
    FOD_DISCH = 2'b01,
    FOD_RECOV = 2'b10,
    FOD_BRAKE = 2'b11
  } fod_state_e;

endpackage : fod_pkg

// ### fod_spi_rx.sv
`timescale 1ns/1ps

module fod_spi_rx
  import fod_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk_pin,
  input wire logic cs_n_pin,
  input wire logic mosi_pin,
  input wire logic [DATA_W-1:0] tx_byte,
  output logic miso_out,
  output logic miso_oe_n,
  output logic frame_valid,
  output logic frame_write,
  output logic [ADDR_W-1:0] frame_addr,
  output logic [DATA_W-1:0] frame_data
);

  ////////////////////////////////////////////////////////////////////////
  logic sclk_s1, sclk_s2, sclk_d;
  logic cs_s1, cs_s2, cs_d;
  logic mosi_s1, mosi_s2;
  logic [FRAME_BITS-1:0] rx_reg;
  logic [FRAME_BITS-1:0] tx_reg;
  logic [4:0] cnt_reg;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise;

  // two-stage synchronisers; the link clock is only a sampled level here
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      {sclk_s1, sclk_s2, sclk_d} <= 3'h0;
      {cs_s1, cs_s2, cs_d} <= 3'h7;
      {mosi_s1, mosi_s2} <= 2'h0;
    end else begin
      sclk_s1 <= sclk_pin;
      sclk_s2 <= sclk_s1;
      sclk_d <= sclk_s2;
      cs_s1 <= cs_n_pin;
      cs_s2 <= cs_s1;
      cs_d <= cs_s2;
      mosi_s1 <= mosi_pin;
      mosi_s2 <= mosi_s1;
    end
  end

  // edges only from synchronised copies
  assign sclk_rise = sclk_s2 & ~sclk_d & ~cs_s2;
  assign sclk_fall = ~sclk_s2 & sclk_d & ~cs_s2;
  assign cs_fall = ~cs_s2 & cs_d;
  assign cs_rise = cs_s2 & ~cs_d;

  // receive shift, mosi sampled on rising sclk
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_reg <= '0;
      cnt_reg <= 5'h00;
    end else if (cs_fall) begin
      cnt_reg <= 5'h00;
    end else if (sclk_rise) begin
      rx_reg <= {rx_reg[FRAME_BITS-2:0], mosi_s2};
      if (cnt_reg != 5'h1F) cnt_reg <= cnt_reg + 5'h01; // saturate on overlong frames
    end
  end

  // status byte loaded at select, shifted on falling sclk
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_reg <= '0;
    end else if (cs_fall) begin
      tx_reg <= {tx_byte, 8'h00};
    end else if (sclk_fall) begin
      tx_reg <= {tx_reg[FRAME_BITS-2:0], 1'b0};
    end
  end

  // frame accepted only with exactly sixteen bits; short or long frames are dropped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_valid <= 1'b0;
      frame_write <= 1'b0;
      frame_addr <= '0;
      frame_data <= '0;
    end else begin
      frame_valid <= cs_rise && (cnt_reg == FRAME_BITS_M1 + 5'h01);
      if (cs_rise) begin
        frame_write <= rx_reg[FRAME_BITS-1];
        frame_addr <= rx_reg[FRAME_BITS-2:DATA_W];
        frame_data <= rx_reg[DATA_W-1:0];
      end
    end
  end

  // miso driven only while selected
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      miso_out <= 1'b0;
      miso_oe_n <= 1'b1;
    end else begin
      miso_out <= tx_reg[FRAME_BITS-1];
      miso_oe_n <= cs_s2;
    end
  end

endmodule : fod_spi_rx

// ### fod_seq.sv
`timescale 1ns/1ps

// Function
// - the start bit has weight 0x10 and the chain ratio sits in the bits below it.
// - the sequence begins at the chip-select rise that ends the frame carrying the start bit.
// - discharge ends when vout reaches numerator over denominator times vout at the start.
// - each chain ratio value also selects the short-circuit detection threshold.
// - preparation time is the delay count plus two switching periods from the jump start.
// - during discharge the inductor current is reversed and held at the switch limit.
// - the limit-halving bit halves the limit, only during discharge.
// - the compensation-softening bit reduces amplifier saturation current, only during discharge.
// - after the target a recovery phase brings current to zero, then the done flag is set.
// - after done both low-side drivers stay on until preparation time expires, then switching resumes.
// - the regulation target can be changed through the analog dimming value.
module fod_seq
  import fod_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso_out,
  output logic spi_miso_oe_n,
  input wire logic [VOUT_W-1:0] vout_sense,
  input wire logic il_zero_pin,
  output logic reverse_current_en,
  output logic discharge_limit_halve,
  output logic comp_discharge_soften,
  output logic brake_low,
  output logic switching_en,
  output logic discharge_done_flag,
  output logic [CHAIN_W-1:0] short_thresh_sel,
  output logic [DATA_W-1:0] analog_dim_value,
  output logic sw_tick
);

  ////////////////////////////////////////////////////////////////////////
  logic rst_s1, rst_n_sync;
  logic il_s1, il_s2;
  logic frame_valid, frame_write;
  logic [ADDR_W-1:0] frame_addr;
  logic [DATA_W-1:0] frame_data;
  logic [DATA_W-1:0] discharge_setup_reg;
  logic [DATA_W-1:0] prep_delay_reg;
  logic [DATA_W-1:0] adim_reg;
  logic [CHAIN_W-1:0] ratio_den_reg;
  logic [CHAIN_W-1:0] ratio_num_reg;
  logic [VOUT_W-1:0] vout_init_reg;
  logic [7:0] div_reg;
  logic [8:0] prep_cnt_reg;
  logic prep_done;
  logic done_reg;
  logic start_req, setup_wr;
  logic target_hit;
  fod_state_e state_reg;

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_s1 <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      rst_s1 <= 1'b1;
      rst_n_sync <= rst_s1;
    end
  end

  // current-zero comparator comes from the analog side, so synchronise it
  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      il_s1 <= 1'b0;
      il_s2 <= 1'b0;
    end else begin
      il_s1 <= il_zero_pin;
      il_s2 <= il_s1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  fod_spi_rx u_spi (
    .clk(core_clk),
    .rst_n(rst_n_sync),
    .sclk_pin(spi_sclk),
    .cs_n_pin(spi_cs_n),
    .mosi_pin(spi_mosi),
    .tx_byte({done_reg, discharge_setup_reg[SOFTEN_POS:0]}),
    .miso_out(spi_miso_out),
    .miso_oe_n(spi_miso_oe_n),
    .frame_valid(frame_valid),
    .frame_write(frame_write),
    .frame_addr(frame_addr),
    .frame_data(frame_data)
  );

  assign setup_wr = frame_valid && frame_write && (frame_addr == ADDR_SETUP);
  assign start_req = setup_wr && frame_data[START_POS] && (state_reg == FOD_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // switching period enable from the core clock divider
  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      div_reg <= 8'h00;
      sw_tick <= 1'b0;
    end else begin
      sw_tick <= (div_reg == SW_DIV_M1);
      div_reg <= (div_reg == SW_DIV_M1) ? 8'h00 : div_reg + 8'h01;
    end
  end

  // register writes; start bit is a command and is not kept
  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      discharge_setup_reg <= SETUP_RST;
      prep_delay_reg <= PREP_RST;
      adim_reg <= ADIM_RST;
    end else if (frame_valid && frame_write) begin
      if (frame_addr == ADDR_SETUP) discharge_setup_reg <= frame_data & ~(8'h01 << START_POS);
      if (frame_addr == ADDR_PREP) prep_delay_reg <= frame_data;
      if (frame_addr == ADDR_ADIM) adim_reg <= frame_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      ratio_den_reg <= '0;
      ratio_num_reg <= '0;
      vout_init_reg <= '0;
    end else if (start_req) begin
      ratio_den_reg <= discharge_setup_reg[CHAIN_W-1:0];
      ratio_num_reg <= frame_data[CHAIN_W-1:0];
      vout_init_reg <= vout_sense;
    end
  end

  // cross-multiplied compare
  // a zero denominator has no meaning, so it ends discharge at once
  assign target_hit = (ratio_den_reg == '0) ||
    (14'(vout_sense) * 14'(ratio_den_reg) <= 14'(vout_init_reg) * 14'(ratio_num_reg));

  // prep timer in switching periods
  // counting restarts at the jump, so it overlaps discharge and recovery
  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      prep_cnt_reg <= 9'h000;
    end else if (start_req) begin
      prep_cnt_reg <= PREP_BASE_PERIODS + 9'(prep_delay_reg);
    end else if (sw_tick && prep_cnt_reg != 9'h000) begin
      prep_cnt_reg <= prep_cnt_reg - 9'h001;
    end
  end
  assign prep_done = (prep_cnt_reg == 9'h000);

  ////////////////////////////////////////////////////////////////////////
  // sequence state; new starts are ignored while busy
  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      state_reg <= FOD_IDLE;
    end else begin
      case (state_reg)
        FOD_IDLE: begin
          if (start_req) state_reg <= FOD_DISCH;
        end
        FOD_DISCH: begin
          if (target_hit) state_reg <= FOD_RECOV;
        end
        FOD_RECOV: begin
          if (il_s2) state_reg <= FOD_BRAKE;
        end
        FOD_BRAKE: begin
          if (prep_done) state_reg <= FOD_IDLE;
        end
        default: state_reg <= FOD_IDLE;
      endcase
    end
  end

  // cleared only by a new start
  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      done_reg <= 1'b0;
    end else if (state_reg == FOD_RECOV && il_s2) begin
      done_reg <= 1'b1;
    end else if (start_req) begin
      done_reg <= 1'b0;
    end
  end

  // registered drive outputs
  always_ff @(posedge core_clk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      reverse_current_en <= 1'b0;
      discharge_limit_halve <= 1'b0;
      comp_discharge_soften <= 1'b0;
      brake_low <= 1'b0;
      switching_en <= 1'b0;
    end else begin
      reverse_current_en <= (state_reg == FOD_DISCH);
      discharge_limit_halve <= (state_reg == FOD_DISCH) && discharge_setup_reg[HALVE_POS];
      comp_discharge_soften <= (state_reg == FOD_DISCH) && discharge_setup_reg[SOFTEN_POS];
      brake_low <= (state_reg == FOD_BRAKE);
      switching_en <= (state_reg == FOD_IDLE);
    end
  end

  assign discharge_done_flag = done_reg;
  assign short_thresh_sel = discharge_setup_reg[CHAIN_W-1:0];
  assign analog_dim_value = adim_reg;

endmodule : fod_seq

// ### fod_seq_checker.sv
`timescale 1ns/1ps

module fod_seq_checker (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic reverse_current_en,
  input wire logic discharge_limit_halve,
  input wire logic comp_discharge_soften,
  input wire logic brake_low,
  input wire logic switching_en,
  input wire logic discharge_done_flag,
  input wire logic sw_tick
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  // brake follows done within a cycle
  sequence s_brake_soon;
    ##[0:1] brake_low;
  endsequence
  // next tick lands 50 cycles after the last one
  sequence s_tick_gap;
    !sw_tick [*8] ##42 sw_tick;
  endsequence

  property p_halve; discharge_limit_halve |-> reverse_current_en; endproperty
  a_halve: assert property (p_halve) else $error("limit halving outside discharge");
  property p_soften; comp_discharge_soften |-> reverse_current_en; endproperty
  a_soften: assert property (p_soften) else $error("softening outside discharge");
  property p_disch; reverse_current_en |-> !switching_en && !brake_low; endproperty
  a_disch: assert property (p_disch) else $error("switching during discharge");
  property p_rec_done; $rose(discharge_done_flag) |-> !$past(reverse_current_en); endproperty
  a_rec_done: assert property (p_rec_done) else $error("done before recovery");
  property p_done_brake; $rose(discharge_done_flag) |-> s_brake_soon; endproperty
  a_done_brake: assert property (p_done_brake) else $error("no brake after done");
  property p_brake_hold; brake_low |-> discharge_done_flag && !switching_en; endproperty
  a_brake_hold: assert property (p_brake_hold) else $error("brake without done");
  property p_resume; $fell(brake_low) |-> ##[0:1] switching_en; endproperty
  a_resume: assert property (p_resume) else $error("switching not resumed");
  property p_tick; sw_tick |=> s_tick_gap; endproperty
  a_tick: assert property (p_tick) else $error("switching period wrong");
  property p_done_clr; $fell(discharge_done_flag) |-> ##[0:1] reverse_current_en; endproperty
  a_done_clr: assert property (p_done_clr) else $error("done cleared without start");
endmodule : fod_seq_checker

bind fod_seq fod_seq_checker u_chk (
  .core_clk(core_clk),
  .arst_n(arst_n),
  .reverse_current_en(reverse_current_en),
  .discharge_limit_halve(discharge_limit_halve),
  .comp_discharge_soften(comp_discharge_soften),
  .brake_low(brake_low),
  .switching_en(switching_en),
  .discharge_done_flag(discharge_done_flag),
  .sw_tick(sw_tick)
);

// ### fod_host_model.sv
`timescale 1ns/1ps

module fod_host_model (
  input wire logic clk,
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso_out,
  input wire logic miso_oe_n
);
  logic miso_line;

  // released line idles high through the pull-up
  assign miso_line = miso_oe_n ? 1'b1 : miso_out;

  // link clock stands low between frames
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  // whole frames
  // 400 ns link period, 4 core cycles per half; msb first
  task automatic xfer(input logic [15:0] frm, output logic [7:0] rx);
    cs_n <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi <= frm[i];
      repeat (4) @(posedge clk);
      sclk <= 1'b1;
      repeat (4) @(posedge clk);
      // miso lags the falling edge by the sync delay, so take it late in the high phase
      if (i > 7) rx[i-8] = miso_line;
      sclk <= 1'b0;
    end
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    // mosi no longer valid: show the inverse
    mosi <= ~frm[0];
    repeat (8) @(posedge clk);
  endtask : xfer
endmodule : fod_host_model

// ### fod_seq_tb_top.sv
`timescale 1ns/1ps

module fod_seq_tb_top import fod_pkg::*;;
  logic core_clk, arst_n, il_zero_pin;
  logic spi_sclk, spi_cs_n, spi_mosi, spi_miso_out, spi_miso_oe_n;
  logic [VOUT_W-1:0] vout_sense;
  logic rev, halve, soften, brake, sw_en, done;
  logic [CHAIN_W-1:0] thr;
  logic [DATA_W-1:0] dim, rx;
  int failures = 0;
  int comparisons = 0;
  int cyc = 0;

  fod_seq u_dut (.core_clk(core_clk), .arst_n(arst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
    .spi_mosi(spi_mosi), .spi_miso_out(spi_miso_out), .spi_miso_oe_n(spi_miso_oe_n),
    .vout_sense(vout_sense), .il_zero_pin(il_zero_pin), .reverse_current_en(rev),
    .discharge_limit_halve(halve), .comp_discharge_soften(soften), .brake_low(brake),
    .switching_en(sw_en), .discharge_done_flag(done), .short_thresh_sel(thr),
    .analog_dim_value(dim), .sw_tick());

  fod_host_model u_host (.clk(core_clk), .sclk(spi_sclk), .cs_n(spi_cs_n), .mosi(spi_mosi),
    .miso_out(spi_miso_out), .miso_oe_n(spi_miso_oe_n));

  // 50 ns core clock and free cycle count
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk) cyc <= cyc + 1;

  ////////////////////////////////////////////////////////////////
  task stop_test;
    if (failures == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test

  task chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  function automatic logic pick(input int sel);
    case (sel)
      0: return rev;
      1: return done;
      2: return sw_en;
      default: return brake;
    endcase
  endfunction : pick

  // bounded wait; running out ends the run as a failure
  task automatic wait_sig(input int sel, input logic lvl, input int lim);
    int n;
    n = 0;
    while (pick(sel) !== lvl) begin
      @(posedge core_clk);
      n++;
      if (n > lim) begin
        failures++;
        stop_test();
      end
    end
  endtask : wait_sig

  // one full discharge; target chosen exact so one code above must keep going
  task automatic run_fd(input logic [7:0] d, input logic [3:0] den, input logic [3:0] num,
    input logic [7:0] fl);
    int t0;
    logic [9:0] tgt;
    tgt = 10'(768 * int'(num) / int'(den));
    u_host.xfer({1'b1, ADDR_PREP, d}, rx);
    u_host.xfer({1'b1, ADDR_SETUP, 4'h0, den}, rx);
    chk(16'(thr), 16'(den));
    vout_sense <= 10'h300;
    u_host.xfer({1'b1, ADDR_SETUP, fl[7:4] | 4'h1, num}, rx);
    t0 = cyc - 8;
    wait_sig(0, 1'b1, 20);
    chk(16'({halve, soften, thr}), 16'({fl[5], fl[6], num}));
    vout_sense <= tgt + 10'h001;
    repeat (10) @(posedge core_clk);
    chk(16'({rev, sw_en}), 16'h2);
    vout_sense <= tgt;
    wait_sig(0, 1'b0, 8);
    repeat (10) @(posedge core_clk);
    chk(16'({done, brake}), 16'h0);
    il_zero_pin <= 1'b1;
    wait_sig(1, 1'b1, 6);
    wait_sig(3, 1'b1, 3);
    wait_sig(2, 1'b1, 600);
    chk(16'(cyc - t0 >= (1 + d) * SW_DIV && cyc - t0 <= (2 + d) * SW_DIV + 10), 16'h1);
    il_zero_pin <= 1'b0;
    chk(16'({done, brake}), 16'h2);
    u_host.xfer({1'b0, ADDR_SETUP, 8'h00}, rx);
    chk(16'(rx), {8'h00, 1'b1, fl[6:5], 1'b0, num});
  endtask : run_fd

  ////////////////////////////////////////////////////////////////
  initial begin
    arst_n = 1'b0;
    il_zero_pin = 1'b0;
    vout_sense = 10'h300;
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk(16'({dim, sw_en, done, spi_miso_oe_n}), 16'h07FD);
    u_host.xfer({1'b1, ADDR_ADIM, 8'h5A}, rx);
    // write to an unmapped address must not disturb anything
    u_host.xfer({1'b1, 7'h7F, 8'h00}, rx);
    chk(16'(dim), 16'h005A);
    run_fd(8'h02, 4'h6, 4'h2, 8'h20);
    run_fd(8'h00, 4'h4, 4'h3, 8'h40);
    stop_test();
  end
endmodule : fod_seq_tb_top
